// File: rtl/slm_pkg.sv
/*
  Shared constants for the lane mux power manager: bus register map, field
  positions, reset values, pin level codes, setting codes and timing counts.
  Assumes a single 40 MHz clock domain.
*/
package slm_pkg;

  // Clock rate
  localparam int unsigned CLK_MHZ = 40;

  // Timing figures in their own units, then in cycles
  localparam int unsigned IDLE_ENTRY_NS = 6;    // U0 input stop to output idle, nominal
  localparam int unsigned EXIT_U23_US   = 1;    // Terminations found to forwarding, from U2/U3
  localparam int unsigned EXIT_DISC_US  = 2;    // Same, from disconnect
  localparam int unsigned IDLE_ENTRY_CYC = ((IDLE_ENTRY_NS * CLK_MHZ) / 1000 > 0) ?
                                           (IDLE_ENTRY_NS * CLK_MHZ) / 1000 : 1;
  localparam int unsigned EXIT_U23_CYC  = EXIT_U23_US * CLK_MHZ;
  localparam int unsigned EXIT_DISC_CYC = EXIT_DISC_US * CLK_MHZ;

  // Counter width shared by all timers
  localparam int unsigned TMR_W = 16;

  // Register byte offsets
  localparam logic [7:0] REG_DET_PERIOD = 8'h00;
  localparam logic [7:0] REG_IDLE_TMO   = 8'h04;
  localparam logic [7:0] REG_STATUS     = 8'h08;
  localparam logic [7:0] REG_CFG        = 8'h0C;

  // Register reset values
  localparam logic [15:0] DET_PERIOD_RST = 16'h0FA0;  // 4000 cycles, 100 us
  localparam logic [15:0] IDLE_TMO_RST   = 16'h0FA0;

  // Status field positions
  localparam int unsigned ST_STATE_LSB  = 0;    // Two bits of power state
  localparam int unsigned ST_TERM_AP    = 2;
  localparam int unsigned ST_TERM_CONN  = 3;
  localparam int unsigned ST_SEL        = 4;
  localparam int unsigned ST_LFPS_AP    = 5;
  localparam int unsigned ST_LFPS_CONN  = 6;
  localparam int unsigned ST_RX_TERM    = 7;
  localparam int unsigned ST_DET_BUSY   = 8;

  // Setting readback positions, five bits each {deemph, swing, gain}
  localparam int unsigned CFG_HOST_LSB  = 0;
  localparam int unsigned CFG_CONN_LSB  = 8;

  // Three-level pin codes
  localparam logic [1:0] LVL_LOW   = 2'h0;
  localparam logic [1:0] LVL_FLOAT = 2'h1;
  localparam logic [1:0] LVL_HIGH  = 2'h2;

  // Setting codes
  localparam logic [1:0] EMPH_0DB   = 2'h0;
  localparam logic [1:0] EMPH_3P5DB = 2'h1;
  localparam logic [1:0] EMPH_6DB   = 2'h2;
  localparam logic [1:0] EMPH_P35DB = 2'h3;     // Printed .35 dB entry
  localparam logic [1:0] GAIN_9DB   = 2'h3;

  // Power states
  typedef enum logic [1:0] {PWR_DISC, PWR_EXIT, PWR_U0, PWR_U23} slm_pwr_e;

endpackage : slm_pkg

// File: rtl/slm_timer.sv
/*
  Loadable down counter. A load puts the value in the counter; done pulses
  in the cycle the count reaches one, so done comes value cycles after load.
  Assumes a synchronous load and an active low asynchronous reset.
*/
`timescale 1ns/1ps
module slm_timer #(
  parameter int unsigned W = 16
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Control
  input  wire logic         load,
  input  wire logic [W-1:0] value,
  // Status
  output      logic         busy,
  output      logic         done
);
  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;

  // Count selection
  assign nxt_cnt = load ? value : ((cnt_ff != '0) ? cnt_ff - W'(1) : '0);
  assign busy    = (cnt_ff != '0);
  assign done    = (cnt_ff == W'(1));

  // Counter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

endmodule : slm_timer

// File: rtl/slm_cfg_decode.sv
/*
  Decodes two three-level strap pins into de-emphasis, swing and gain codes
  for one channel. Assumes the pins are sensed as level codes; the unused
  code is read as floating.
*/
`timescale 1ns/1ps
module slm_cfg_decode #(
  parameter bit CONN_SIDE = 1'b0
) (
  // Sensed pin levels
  input  wire logic [1:0] pin_a,
  input  wire logic [1:0] pin_b,
  // Decoded settings
  output      logic [1:0] deemph,
  output      logic       swing,
  output      logic [1:0] gain
);
  // Entries {deemph, swing 1=1.1V, gain}, index a*3+b with L,F,H = 0,1,2
  localparam logic [4:0] HOST_TBL [9] = '{5'h0D, 5'h09, 5'h05, 5'h01, 5'h0C, 5'h18, 5'h04, 5'h00, 5'h16};
  localparam logic [4:0] CONN_TBL [9] = '{5'h14, 5'h0C, 5'h08, 5'h10, 5'h0E, 5'h0A, 5'h16, 5'h12, 5'h17};

  logic [1:0] a_lvl;
  logic [1:0] b_lvl;
  logic [3:0] idx;
  logic [4:0] entry;

  // Three-level reading, unused code taken as floating  R4
  assign a_lvl = (pin_a == slm_pkg::LVL_HIGH) ? 2'h2 : ((pin_a == slm_pkg::LVL_LOW) ? 2'h0 : 2'h1);
  assign b_lvl = (pin_b == slm_pkg::LVL_HIGH) ? 2'h2 : ((pin_b == slm_pkg::LVL_LOW) ? 2'h0 : 2'h1);
  assign idx   = 4'({a_lvl, 1'b0}) + 4'(a_lvl) + 4'(b_lvl);

  // Table lookup  R5 R6
  assign entry  = CONN_SIDE ? CONN_TBL[idx] : HOST_TBL[idx];
  assign deemph = entry[4:3];
  assign swing  = entry[2];
  assign gain   = entry[1:0];

endmodule : slm_cfg_decode

// File: rtl/slm_lane_mux_pm.sv
/*
  Control logic of a two channel re-driver with a 2:1 lane mux: routing by
  orientation select, strap-pin signal conditioning, automatic de-emphasis
  off during periodic low-frequency signaling, and the power state machine.
  Assumes the analog front end reports receiver detection, low-frequency
  signaling and traffic as levels synchronous to CLK, and a Wishbone master.
*/
`timescale 1ns/1ps

// Function
// R1 - Select high routes port 1, grounds 2
// R2 - Select low routes port 2, grounds 1
// R3 - Unselected receive pair weakly terminated
// R4 - Strap pins read as three levels
// R5 - Host-side straps pick host settings
// R6 - Connector-side straps pick connector settings
// R7 - Signaling seen disables opposite de-emphasis
// R8 - Repeat receiver detection after power-up
// R9 - Enable receive termination once detected
// R10 - Active, low-power and disconnect modes
// R11 - Disconnect periodically detects both terminations
// R12 - Leave disconnect only with both terminations
// R13 - Stay in U0 while traffic arrives
// R14 - Periodic detection continues in U2/U3
// R15 - Output idles shortly after input stops
// R16 - Forwarding delay 1 us or 2 us
// R17 - Long idle enters U2/U3, activity wakes
// R18 - Lost termination returns to disconnect
module slm_lane_mux_pm (
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RSTN,
  // Wishbone slave
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output      logic [31:0] WB_DAT_O,
  output      logic        WB_ACK_O,
  // Orientation and strap pins
  input  wire logic        ORIENT_SEL,
  input  wire logic [1:0]  HOST_SIDE_CFG_PIN_A,
  input  wire logic [1:0]  HOST_SIDE_CFG_PIN_B,
  input  wire logic [1:0]  CONN_SIDE_CFG_PIN_A,
  input  wire logic [1:0]  CONN_SIDE_CFG_PIN_B,
  // Analog front end status
  input  wire logic        RXDET_DONE,
  input  wire logic        FAR_TERM_AP,
  input  wire logic        FAR_TERM_CONN,
  input  wire logic        LFPS_SEEN_AP,
  input  wire logic        LFPS_SEEN_CONN,
  input  wire logic        TRAFFIC_AP,
  input  wire logic        TRAFFIC_CONN,
  // Receiver detection and termination
  output      logic        RXDET_START,
  output      logic        RX_TERM_EN,
  // Lane mux
  output      logic        CONN1_LINK_EN,
  output      logic        CONN2_LINK_EN,
  output      logic        CONN1_GROUND_EN,
  output      logic        CONN2_GROUND_EN,
  output      logic        CONN1_RX_WEAK_TERM,
  output      logic        CONN2_RX_WEAK_TERM,
  // Drivers and signal conditioning
  output      logic        AP_TX_DRIVE_EN,
  output      logic        CONN_TX_DRIVE_EN,
  output      logic [1:0]  AP_TX_DEEMPH_LEVEL,
  output      logic        AP_TX_SWING_LEVEL,
  output      logic [1:0]  AP_RX_GAIN_SETTING,
  output      logic [1:0]  CONN_TX_DEEMPH_LEVEL,
  output      logic        CONN_TX_SWING_LEVEL,
  output      logic [1:0]  CONN_RX_GAIN_SETTING,
  output      logic [1:0]  POWER_STATE
);
  localparam int unsigned TW = slm_pkg::TMR_W;

  slm_pkg::slm_pwr_e state_ff;
  slm_pkg::slm_pwr_e nxt_state;
  logic [15:0]       det_period_ff;
  logic [15:0]       idle_tmo_ff;
  logic              ack_ff;
  logic [31:0]       dat_ff;
  logic              det_busy_ff;
  logic              wake_ff;
  logic              term_ap_ff;
  logic              term_conn_ff;
  logic [1:0]        host_emph;
  logic              host_sw;
  logic [1:0]        host_gain;
  logic [1:0]        conn_emph;
  logic              conn_sw;
  logic [1:0]        conn_gain;
  logic              det_tick;
  logic              det_tmr_busy;
  logic              exit_done;
  logic              idle_done;
  logic              hold_ap_busy;
  logic              hold_conn_busy;

  // Strap decoding per channel  R5 R6
  slm_cfg_decode #(.CONN_SIDE(1'b0)) u_host_cfg (
    .pin_a  (HOST_SIDE_CFG_PIN_A),
    .pin_b  (HOST_SIDE_CFG_PIN_B),
    .deemph (host_emph),
    .swing  (host_sw),
    .gain   (host_gain)
  );
  slm_cfg_decode #(.CONN_SIDE(1'b1)) u_conn_cfg (
    .pin_a  (CONN_SIDE_CFG_PIN_A),
    .pin_b  (CONN_SIDE_CFG_PIN_B),
    .deemph (conn_emph),
    .swing  (conn_sw),
    .gain   (conn_gain)
  );

  // Bus decode
  wire        wb_hit     = WB_CYC_I & WB_STB_I & ~ack_ff;
  wire        wb_wr      = wb_hit & WB_WE_I;
  wire        sel_period = (WB_ADR_I == slm_pkg::REG_DET_PERIOD);
  wire        sel_tmo    = (WB_ADR_I == slm_pkg::REG_IDLE_TMO);
  wire        sel_status = (WB_ADR_I == slm_pkg::REG_STATUS);
  wire        sel_cfg    = (WB_ADR_I == slm_pkg::REG_CFG);
  wire [31:0] status_word;
  wire [31:0] cfg_word;
  wire [31:0] rd_data;
  wire [15:0] nxt_period;
  wire [15:0] nxt_tmo;

  assign status_word = 32'({det_busy_ff, RX_TERM_EN, LFPS_SEEN_CONN, LFPS_SEEN_AP, ORIENT_SEL,
                            term_conn_ff, term_ap_ff, state_ff}) << slm_pkg::ST_STATE_LSB;
  assign cfg_word    = (32'({host_emph, host_sw, host_gain}) << slm_pkg::CFG_HOST_LSB) |
                       (32'({conn_emph, conn_sw, conn_gain}) << slm_pkg::CFG_CONN_LSB);
  assign rd_data     = sel_period ? 32'(det_period_ff) :
                       sel_tmo    ? 32'(idle_tmo_ff)   :
                       sel_status ? status_word        :
                       sel_cfg    ? cfg_word           : 32'h0000_0000;
  assign nxt_period  = {WB_SEL_I[1] ? WB_DAT_I[15:8] : det_period_ff[15:8],
                        WB_SEL_I[0] ? WB_DAT_I[7:0]  : det_period_ff[7:0]};
  assign nxt_tmo     = {WB_SEL_I[1] ? WB_DAT_I[15:8] : idle_tmo_ff[15:8],
                        WB_SEL_I[0] ? WB_DAT_I[7:0]  : idle_tmo_ff[7:0]};

  // Bus slave: ack one cycle after the request, unmapped reads zero
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      ack_ff        <= 1'b0;
      dat_ff        <= 32'h0000_0000;
      det_period_ff <= slm_pkg::DET_PERIOD_RST;
      idle_tmo_ff   <= slm_pkg::IDLE_TMO_RST;
    end else begin
      ack_ff        <= wb_hit;
      dat_ff        <= (wb_hit && !WB_WE_I) ? rd_data : 32'h0000_0000;
      det_period_ff <= (wb_wr && sel_period) ? nxt_period : det_period_ff;
      idle_tmo_ff   <= (wb_wr && sel_tmo) ? nxt_tmo : idle_tmo_ff;
    end
  end

  // Detection events
  wire both_term   = FAR_TERM_AP & FAR_TERM_CONN;
  wire det_result  = det_busy_ff & RXDET_DONE;
  wire det_idle_st = (state_ff == slm_pkg::PWR_DISC) || (state_ff == slm_pkg::PWR_U23);
  wire wake_req    = (state_ff == slm_pkg::PWR_U23) & (wake_ff | LFPS_SEEN_AP | LFPS_SEEN_CONN);
  wire det_launch  = det_idle_st & ~det_busy_ff & (det_tick | wake_req);  // R8 R11 R14
  wire traffic_any = TRAFFIC_AP | TRAFFIC_CONN;

  // Periodic detection tick, reloaded whenever it runs out
  slm_timer #(.W(TW)) u_det_tmr (
    .clk   (CLK),
    .rst_n (RSTN),
    .load  (~det_tmr_busy),
    .value (det_period_ff),
    .busy  (det_tmr_busy),
    .done  (det_tick)
  );

  // Power state machine  R10
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      slm_pkg::PWR_DISC: begin
        if (det_result && both_term) begin
          nxt_state = slm_pkg::PWR_EXIT;  // R12
        end
      end
      slm_pkg::PWR_U23: begin
        if (det_result && !both_term) begin
          nxt_state = slm_pkg::PWR_DISC;  // R18
        end else if (det_result && wake_ff) begin
          nxt_state = slm_pkg::PWR_EXIT;  // R17
        end
      end
      slm_pkg::PWR_EXIT: begin
        if (exit_done) begin
          nxt_state = slm_pkg::PWR_U0;  // R16
        end
      end
      slm_pkg::PWR_U0: begin
        if (idle_done && !traffic_any) begin
          nxt_state = slm_pkg::PWR_U23;  // R13 R17
        end
      end
      default: begin
        nxt_state = slm_pkg::PWR_DISC;
      end
    endcase
  end

  // Forwarding delay after terminations found
  wire            exit_load = (state_ff != slm_pkg::PWR_EXIT) && (nxt_state == slm_pkg::PWR_EXIT);
  wire [TW-1:0]   exit_val  = (state_ff == slm_pkg::PWR_DISC) ? TW'(slm_pkg::EXIT_DISC_CYC)
                                                              : TW'(slm_pkg::EXIT_U23_CYC);
  slm_timer #(.W(TW)) u_exit_tmr (
    .clk   (CLK),
    .rst_n (RSTN),
    .load  (exit_load),  // R16
    .value (exit_val),
    .busy  (),
    .done  (exit_done)
  );

  // Idle timeout, restarted by any traffic or outside U0
  slm_timer #(.W(TW)) u_idle_tmr (
    .clk   (CLK),
    .rst_n (RSTN),
    .load  (traffic_any || (state_ff != slm_pkg::PWR_U0)),  // R13
    .value (idle_tmo_ff),
    .busy  (),
    .done  (idle_done)
  );

  // Electrical idle entry holds, one per direction
  slm_timer #(.W(TW)) u_hold_ap (
    .clk   (CLK),
    .rst_n (RSTN),
    .load  (TRAFFIC_CONN),
    .value (TW'(slm_pkg::IDLE_ENTRY_CYC - 1)),
    .busy  (hold_ap_busy),
    .done  ()
  );
  slm_timer #(.W(TW)) u_hold_conn (
    .clk   (CLK),
    .rst_n (RSTN),
    .load  (TRAFFIC_AP),
    .value (TW'(slm_pkg::IDLE_ENTRY_CYC - 1)),
    .busy  (hold_conn_busy),
    .done  ()
  );

  // Next output values
  wire       in_u0          = (state_ff == slm_pkg::PWR_U0);
  wire       nxt_ap_drive   = in_u0 & (TRAFFIC_CONN | hold_ap_busy);  // R15
  wire       nxt_conn_drive = in_u0 & (TRAFFIC_AP | hold_conn_busy);  // R15
  wire [1:0] nxt_ap_emph    = LFPS_SEEN_CONN ? slm_pkg::EMPH_0DB : host_emph;  // R7
  wire [1:0] nxt_conn_emph  = LFPS_SEEN_AP ? slm_pkg::EMPH_0DB : conn_emph;  // R7
  wire       nxt_rx_term    = (nxt_state != slm_pkg::PWR_DISC);  // R9
  wire       nxt_busy       = (det_busy_ff & ~RXDET_DONE) | det_launch;
  wire       nxt_wake       = (state_ff == slm_pkg::PWR_U23) & (nxt_state == slm_pkg::PWR_U23) & wake_req;

  // State, detection and wake tracking
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_ff     <= slm_pkg::PWR_DISC;
      det_busy_ff  <= 1'b0;
      wake_ff      <= 1'b0;
      term_ap_ff   <= 1'b0;
      term_conn_ff <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      det_busy_ff  <= nxt_busy;
      wake_ff      <= nxt_wake;  // R17
      term_ap_ff   <= det_result ? FAR_TERM_AP : term_ap_ff;
      term_conn_ff <= det_result ? FAR_TERM_CONN : term_conn_ff;
    end
  end

  // Registered outputs
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      RXDET_START          <= 1'b0;
      RX_TERM_EN           <= 1'b0;
      CONN1_LINK_EN        <= 1'b0;
      CONN2_LINK_EN        <= 1'b0;
      CONN1_GROUND_EN      <= 1'b1;
      CONN2_GROUND_EN      <= 1'b1;
      CONN1_RX_WEAK_TERM   <= 1'b1;
      CONN2_RX_WEAK_TERM   <= 1'b1;
      AP_TX_DRIVE_EN       <= 1'b0;
      CONN_TX_DRIVE_EN     <= 1'b0;
      AP_TX_DEEMPH_LEVEL   <= slm_pkg::EMPH_0DB;
      AP_TX_SWING_LEVEL    <= 1'b0;
      AP_RX_GAIN_SETTING   <= 2'h0;
      CONN_TX_DEEMPH_LEVEL <= slm_pkg::EMPH_0DB;
      CONN_TX_SWING_LEVEL  <= 1'b0;
      CONN_RX_GAIN_SETTING <= 2'h0;
      POWER_STATE          <= 2'h0;
    end else begin
      RXDET_START          <= det_launch;  // R8 R11 R14
      RX_TERM_EN           <= nxt_rx_term;  // R9
      CONN1_LINK_EN        <= ORIENT_SEL;  // R1
      CONN2_LINK_EN        <= ~ORIENT_SEL;  // R2
      CONN1_GROUND_EN      <= ~ORIENT_SEL;  // R2
      CONN2_GROUND_EN      <= ORIENT_SEL;  // R1
      CONN1_RX_WEAK_TERM   <= ~ORIENT_SEL;  // R3
      CONN2_RX_WEAK_TERM   <= ORIENT_SEL;  // R3
      AP_TX_DRIVE_EN       <= nxt_ap_drive;
      CONN_TX_DRIVE_EN     <= nxt_conn_drive;
      AP_TX_DEEMPH_LEVEL   <= nxt_ap_emph;
      AP_TX_SWING_LEVEL    <= host_sw;
      AP_RX_GAIN_SETTING   <= host_gain;
      CONN_TX_DEEMPH_LEVEL <= nxt_conn_emph;
      CONN_TX_SWING_LEVEL  <= conn_sw;
      CONN_RX_GAIN_SETTING <= conn_gain;
      POWER_STATE          <= nxt_state;
    end
  end

  assign WB_ACK_O = ack_ff;
  assign WB_DAT_O = dat_ff;

  // Checks
  localparam int A_DISC_DLY = 80;
  localparam int A_U23_DLY  = 40;
  logic chk_live_ff;

  // Checks wait one edge past reset release, when outputs first leave reset values
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      chk_live_ff <= 1'b0;
    end else begin
      chk_live_ff <= 1'b1;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN || !chk_live_ff);

  a_sel_high_route: assert property (ORIENT_SEL |=> CONN1_LINK_EN && CONN2_GROUND_EN && !CONN2_LINK_EN) // R1
    else $error("Select high did not route port 1");
  a_sel_low_route: assert property (!ORIENT_SEL |=> CONN2_LINK_EN && CONN1_GROUND_EN && !CONN1_LINK_EN) // R2
    else $error("Select low did not route port 2");
  a_weak_term_side: assert property (##1 CONN2_RX_WEAK_TERM == $past(ORIENT_SEL) && CONN1_RX_WEAK_TERM != CONN2_RX_WEAK_TERM) // R3
    else $error("Weak termination on wrong port");
  a_host_ll_set: assert property (HOST_SIDE_CFG_PIN_A == slm_pkg::LVL_LOW && HOST_SIDE_CFG_PIN_B == slm_pkg::LVL_LOW
                                  && !LFPS_SEEN_CONN |=> AP_TX_DEEMPH_LEVEL == slm_pkg::EMPH_3P5DB
                                  && AP_TX_SWING_LEVEL && AP_RX_GAIN_SETTING == 2'h1) // R5
    else $error("Host low-low setting wrong");
  a_conn_hh_gain: assert property (CONN_SIDE_CFG_PIN_A == slm_pkg::LVL_HIGH && CONN_SIDE_CFG_PIN_B == slm_pkg::LVL_HIGH
                                   |=> CONN_RX_GAIN_SETTING == slm_pkg::GAIN_9DB) // R6
    else $error("Connector high-high gain wrong");
  a_lfps_deemph_off: assert property (LFPS_SEEN_CONN |=> AP_TX_DEEMPH_LEVEL == slm_pkg::EMPH_0DB) // R7
    else $error("De-emphasis kept during periodic signaling");
  a_disc_needs_both: assert property ($rose(state_ff == slm_pkg::PWR_EXIT) && $past(state_ff == slm_pkg::PWR_DISC)
                                      |-> $past(RXDET_DONE && FAR_TERM_AP && FAR_TERM_CONN)) // R12
    else $error("Left disconnect without both terminations");
  a_disc_exit_dly: assert property ($rose(state_ff == slm_pkg::PWR_EXIT) && $past(state_ff == slm_pkg::PWR_DISC)
                                    |-> ##A_DISC_DLY state_ff == slm_pkg::PWR_U0) // R16
    else $error("Disconnect exit delay wrong");
  a_u23_exit_dly: assert property ($rose(state_ff == slm_pkg::PWR_EXIT) && $past(state_ff == slm_pkg::PWR_U23)
                                   |-> ##A_U23_DLY state_ff == slm_pkg::PWR_U0) // R16
    else $error("U2/U3 exit delay wrong");
  a_u0_traffic_stay: assert property (state_ff == slm_pkg::PWR_U0 && (TRAFFIC_AP || TRAFFIC_CONN)
                                      |=> state_ff == slm_pkg::PWR_U0) // R13
    else $error("Left U0 while traffic present");
  a_idle_entry_out: assert property (!TRAFFIC_CONN ##1 !TRAFFIC_CONN |=> !AP_TX_DRIVE_EN) // R15
    else $error("Output not idle after input stopped");
  a_lost_term_disc: assert property (state_ff == slm_pkg::PWR_U23 && det_busy_ff && RXDET_DONE
                                     && !(FAR_TERM_AP && FAR_TERM_CONN)
                                     |=> state_ff == slm_pkg::PWR_DISC ##1 !RX_TERM_EN) // R18
    else $error("Lost termination not handled");

  c_disc_to_exit: cover property (state_ff == slm_pkg::PWR_DISC ##1 state_ff == slm_pkg::PWR_EXIT);
  c_enter_u0: cover property (state_ff == slm_pkg::PWR_EXIT ##1 state_ff == slm_pkg::PWR_U0);
  c_enter_u23: cover property (state_ff == slm_pkg::PWR_U0 ##1 state_ff == slm_pkg::PWR_U23);
  c_u23_to_disc: cover property (state_ff == slm_pkg::PWR_U23 ##1 state_ff == slm_pkg::PWR_DISC);

endmodule : slm_lane_mux_pm

// File: test/slm_afe_model.sv
/*
  Front end stand-in: answers each detection start lat+2 cycles later with
  the termination levels the bench picks. Assumes start is a 1-cycle pulse.
*/
`timescale 1ns/1ps
module slm_afe_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Bench controls
  input  wire logic       term_ap,
  input  wire logic       term_conn,
  input  wire logic [3:0] lat,
  // Detection link
  input  wire logic       start,
  output      logic       done,
  output      logic       far_term_ap,
  output      logic       far_term_conn
);
  logic [4:0] cnt_ff;
  logic       fire;
  assign fire = (cnt_ff == 5'h01);
  // Latency count; terms toggle when not reported so stale values never match
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff        <= 5'h00;
      done          <= 1'b0;
      far_term_ap   <= 1'b0;
      far_term_conn <= 1'b0;
    end else begin
      cnt_ff        <= start ? {1'b0, lat} + 5'h01 : (cnt_ff != 5'h00) ? cnt_ff - 5'h01 : 5'h00;
      done          <= fire;
      far_term_ap   <= fire ? term_ap : ~far_term_ap;
      far_term_conn <= fire ? term_conn : ~far_term_conn;
    end
  end
endmodule : slm_afe_model

// File: test/test_slm_lane_mux_pm.sv
/*
  Bench for the lane mux power manager: bus registers, mux, straps, power walk.
  Assumes the front end stand-in answers each detection start.
*/
`timescale 1ns/1ps
module test_slm_lane_mux_pm;
  logic CLK = 1'b0, RSTN = 1'b0, WB_CYC_I = 1'b0, WB_STB_I = 1'b0, WB_WE_I = 1'b0, WB_ACK_O;
  logic [7:0]  WB_ADR_I = 8'h00;
  logic [3:0]  WB_SEL_I = 4'h0;
  logic [31:0] WB_DAT_I = 32'h0000_0000, WB_DAT_O, rd;
  logic ORIENT_SEL = 1'b0, LFPS_SEEN_AP = 1'b0, LFPS_SEEN_CONN = 1'b0, TRAFFIC_AP = 1'b0, TRAFFIC_CONN = 1'b0;
  logic [1:0] HOST_SIDE_CFG_PIN_A = 2'h0, HOST_SIDE_CFG_PIN_B = 2'h0;
  logic [1:0] CONN_SIDE_CFG_PIN_A = 2'h0, CONN_SIDE_CFG_PIN_B = 2'h0;
  logic RXDET_DONE, FAR_TERM_AP, FAR_TERM_CONN, RXDET_START, RX_TERM_EN, CONN1_LINK_EN, CONN2_LINK_EN;
  logic CONN1_GROUND_EN, CONN2_GROUND_EN, CONN1_RX_WEAK_TERM, CONN2_RX_WEAK_TERM, AP_TX_DRIVE_EN;
  logic CONN_TX_DRIVE_EN, AP_TX_SWING_LEVEL, CONN_TX_SWING_LEVEL;
  logic [1:0] AP_TX_DEEMPH_LEVEL, AP_RX_GAIN_SETTING, CONN_TX_DEEMPH_LEVEL, CONN_RX_GAIN_SETTING, POWER_STATE;
  logic term_ap = 1'b0, term_conn = 1'b0;
  int errors = 0, check_count = 0, n;
  // Expected {deemph, swing, gain} per strap pair, index a*3+b; last entry is code 3 with low
  localparam logic [4:0] HOST_EXP [10] = '{5'h0D, 5'h09, 5'h05, 5'h01, 5'h0C, 5'h18, 5'h04, 5'h00, 5'h16, 5'h01};
  localparam logic [4:0] CONN_EXP [10] = '{5'h14, 5'h0C, 5'h08, 5'h10, 5'h0E, 5'h0A, 5'h16, 5'h12, 5'h17, 5'h10};

  slm_lane_mux_pm dut (.*);
  slm_afe_model afe (.clk(CLK), .rst_n(RSTN), .term_ap(term_ap), .term_conn(term_conn), .lat(4'h3),
    .start(RXDET_START), .done(RXDET_DONE), .far_term_ap(FAR_TERM_AP), .far_term_conn(FAR_TERM_CONN));

  // 40 MHz clock
  always #12.5 CLK = ~CLK;

  // Comparison, verdict and hang handling
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic report_and_stop();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  task automatic hang(input string what);
    check(what, 0, 1);
    report_and_stop();
  endtask : hang

  // One classic Wishbone cycle; read data lands in rd
  task automatic wb(input logic [7:0] adr, input logic we, input logic [31:0] wd);
    int k;
    k = 0;
    @(posedge CLK);
    WB_CYC_I <= 1'b1;
    WB_STB_I <= 1'b1;
    WB_WE_I  <= we;
    WB_ADR_I <= adr;
    WB_SEL_I <= 4'h3;
    WB_DAT_I <= wd;
    do begin
      @(posedge CLK);
      k++;
    end while (WB_ACK_O !== 1'b1 && k < 20);
    rd = WB_DAT_O;
    WB_CYC_I <= 1'b0;
    WB_STB_I <= 1'b0;
    if (k >= 20) hang("bus ack");
  endtask : wb

  // Waits and counts on settled outputs
  task automatic wait_state(input logic [1:0] s);
    int k;
    k = 0;
    while (POWER_STATE !== s && k < 3000) begin
      @(negedge CLK);
      k++;
    end
    if (k >= 3000) hang("power state wait");
  endtask : wait_state
  task automatic count_starts();
    n = 0;
    for (int k = 0; k < 4300 && n < 3; k++) begin
      @(negedge CLK);
      n += int'(RXDET_START === 1'b1);
    end
    if (n < 3) hang("detection starts");
  endtask : count_starts
  task automatic count_exit();
    n = 0;
    while (POWER_STATE === 2'h1 && n < 500) begin
      @(negedge CLK);
      n++;
    end
    if (n >= 500) hang("exit wait");
  endtask : count_exit

  // Main sequence
  initial begin
    repeat (8) @(posedge CLK);
    RSTN <= 1'b1;
    @(negedge CLK);
    check("power state", POWER_STATE, 0);
    check("rx term", RX_TERM_EN, 0);
    wb(slm_pkg::REG_DET_PERIOD, 1'b0, 0);
    check("period reset", rd, {16'h0000, slm_pkg::DET_PERIOD_RST});
    wb(8'h40, 1'b1, 32'hFFFF_FFFF);
    wb(8'h40, 1'b0, 0);
    check("unmapped read", rd, 0);
    wb(slm_pkg::REG_DET_PERIOD, 1'b1, 32'h0000_0014);
    wb(slm_pkg::REG_IDLE_TMO, 1'b1, 32'h0000_001E);
    for (int s = 0; s < 2; s++) begin
      @(posedge CLK);
      ORIENT_SEL <= s[0];
      repeat (2) @(negedge CLK);
      check("port1 routed", {CONN1_LINK_EN, CONN2_GROUND_EN, CONN2_RX_WEAK_TERM}, {3{s[0]}});
      check("port2 routed", {CONN2_LINK_EN, CONN1_GROUND_EN, CONN1_RX_WEAK_TERM}, {3{~s[0]}});
    end
    for (int i = 0; i < 10; i++) begin
      @(posedge CLK);
      HOST_SIDE_CFG_PIN_A <= 2'(i / 3);
      HOST_SIDE_CFG_PIN_B <= 2'(i % 3);
      CONN_SIDE_CFG_PIN_A <= 2'(i / 3);
      CONN_SIDE_CFG_PIN_B <= 2'(i % 3);
      repeat (2) @(negedge CLK);
      check("host setting", {AP_TX_DEEMPH_LEVEL, AP_TX_SWING_LEVEL, AP_RX_GAIN_SETTING}, HOST_EXP[i]);
      check("conn setting", {CONN_TX_DEEMPH_LEVEL, CONN_TX_SWING_LEVEL, CONN_RX_GAIN_SETTING}, CONN_EXP[i]);
    end
    @(posedge CLK);
    HOST_SIDE_CFG_PIN_A <= 2'h2;
    HOST_SIDE_CFG_PIN_B <= 2'h2;
    term_ap <= 1'b1;
    count_starts();
    check("disc detections", n >= 2, 1);
    check("one side only", POWER_STATE, 0);
    term_conn <= 1'b1;
    wait_state(2'h1);
    check("rx term on", RX_TERM_EN, 1);
    count_exit();
    check("exit from disconnect", n, slm_pkg::EXIT_DISC_CYC);
    check("in U0", POWER_STATE, 2);
    @(posedge CLK);
    TRAFFIC_AP   <= 1'b1;
    TRAFFIC_CONN <= 1'b1;
    repeat (60) @(negedge CLK);
    check("stays U0", POWER_STATE, 2);
    check("drivers on", {AP_TX_DRIVE_EN, CONN_TX_DRIVE_EN}, 2'h3);
    @(posedge CLK);
    TRAFFIC_AP   <= 1'b0;
    TRAFFIC_CONN <= 1'b0;
    repeat (2) @(negedge CLK);
    check("drivers idle", {AP_TX_DRIVE_EN, CONN_TX_DRIVE_EN}, 2'h0);
    wait_state(2'h3);
    count_starts();
    check("U2U3 detections", n >= 2, 1);
    @(posedge CLK);
    LFPS_SEEN_CONN <= 1'b1;
    repeat (2) @(negedge CLK);
    check("ap deemph off", AP_TX_DEEMPH_LEVEL, slm_pkg::EMPH_0DB);
    check("conn deemph kept", CONN_TX_DEEMPH_LEVEL, slm_pkg::EMPH_6DB);
    wait_state(2'h1);
    count_exit();
    check("exit from U2U3", n, slm_pkg::EXIT_U23_CYC);
    @(posedge CLK);
    LFPS_SEEN_CONN <= 1'b0;
    term_ap        <= 1'b0;
    repeat (2) @(negedge CLK);
    check("ap deemph back", AP_TX_DEEMPH_LEVEL, slm_pkg::EMPH_6DB);
    wait_state(2'h3);
    wait_state(2'h0);
    repeat (2) @(negedge CLK);
    check("rx term off", RX_TERM_EN, 0);
    report_and_stop();
  end
endmodule : test_slm_lane_mux_pm
